//--- erb_pkg.sv
/*
  Constants, enumerations and block geometries of the embedded RAM block.
  Assumes one fabric clock; all modules but erb_user import the whole package.
*/
// Behaviour
// - Three block sizes: 32x18, 128x36 and 4Kx144 native geometries.
// - True dual-port on medium and large: each port reads or writes.
// - Simple dual-port: read with write; collision: old or undefined.
// - Single-port: no read with write; written data shows on output.
// - Clear hits input and output registers, large block outputs only.
// - Dual-port configurations allow different write and read widths.
// - Address, data and enables registered; write strobe derived internally from clock.
// - Small/medium simple dual-port: flow-through read, negedge capture.
// - Medium block hosts two single-port memories, each half capacity.
// - Input clear acts now, shows at next edge; output clear at once.
package erb_pkg;

  // ****************************************
  // Block sizes and modes
  // ****************************************
  typedef enum logic [2:0] {
    ERB_SMALL  = 3'h1,
    ERB_MEDIUM = 3'h2,
    ERB_LARGE  = 3'h4
  } erb_size_e;

  typedef enum logic [3:0] {
    ERB_TRUE_DP    = 4'h1,
    ERB_SIMPLE_DP  = 4'h2,
    ERB_SINGLE     = 4'h4,
    ERB_TWO_SINGLE = 4'h8
  } erb_mode_e;

  // ****************************************
  // Native geometries
  // ****************************************
  localparam int ERB_SMALL_WORDS = 32;
  localparam int ERB_SMALL_WIDTH = 18;
  localparam int ERB_MEDIUM_WORDS = 128;
  localparam int ERB_MEDIUM_WIDTH = 36;
  localparam int ERB_LARGE_WORDS = 4096;
  localparam int ERB_LARGE_WIDTH = 144;

  // Value of output and input registers after reset or clear
  localparam logic ERB_CLEAR_BIT = 1'b0;
  // Fill used for undefined collision data
  localparam logic ERB_UNDEF_BIT = 1'b1;

  function automatic int erb_bits(erb_size_e s);
    int b;
    case (s)
      ERB_SMALL: b = ERB_SMALL_WORDS * ERB_SMALL_WIDTH;
      ERB_MEDIUM: b = ERB_MEDIUM_WORDS * ERB_MEDIUM_WIDTH;
      default: b = ERB_LARGE_WORDS * ERB_LARGE_WIDTH;
    endcase
    return b;
  endfunction

endpackage

//--- erb_out_stage.sv
/*
  Read data output stage of one port: optional pipeline register.
  Assumes load and data come from logic on the same clock.
*/
module erb_out_stage
  import erb_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clr,
  input wire logic i_use_reg,
  input wire logic i_load,
  input wire logic [W-1:0] i_data,
  output logic [W-1:0] o_q
);

  logic [W-1:0] pipe;
  logic pipe_load;

  always_ff @(posedge i_clk) begin
    if (i_rst || i_clr) begin
      pipe <= {W{ERB_CLEAR_BIT}};
      pipe_load <= 1'b0;
    end else begin
      pipe_load <= i_load && i_use_reg;
      if (i_load) begin
        pipe <= i_data;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_clr) begin
      o_q <= {W{ERB_CLEAR_BIT}};
    end else if (i_use_reg) begin
      if (pipe_load) begin
        o_q <= pipe;
      end
    end else if (i_load) begin
      o_q <= i_data;
    end
  end

endmodule

//--- erb_ram.sv
/*
  Embedded RAM block: true/simple dual-port, single-port and split
  single-port use, mixed widths, optional output registers.
  Assumes user logic on i_clk drives all inputs.
*/
module erb_ram
  import erb_pkg::*;
#(
  parameter erb_size_e SIZE = ERB_MEDIUM,
  parameter int UNIT_W = 1,
  parameter int A_UNITS = 1,
  parameter int B_UNITS = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire erb_mode_e i_mode,
  input wire logic i_clr,
  input wire logic i_out_reg_a,
  input wire logic i_out_reg_b,
  input wire logic i_old_data,
  input wire logic i_flow,
  input wire logic [$clog2(erb_bits(SIZE)/UNIT_W/A_UNITS)-1:0] i_a_addr,
  input wire logic [UNIT_W*A_UNITS-1:0] i_a_wdata,
  input wire logic i_a_wren,
  input wire logic i_a_rden,
  input wire logic [$clog2(erb_bits(SIZE)/UNIT_W/B_UNITS)-1:0] i_b_addr,
  input wire logic [UNIT_W*B_UNITS-1:0] i_b_wdata,
  input wire logic i_b_wren,
  input wire logic i_b_rden,
  output logic [UNIT_W*A_UNITS-1:0] o_a_q,
  output logic [UNIT_W*B_UNITS-1:0] o_b_q
);

  // ****************************************
  // Geometry
  // ****************************************
  localparam int CELLS = erb_bits(SIZE) / UNIT_W;
  localparam int HALF = CELLS / 2;
  localparam int AW_A = $clog2(CELLS / A_UNITS);
  localparam int AW_B = $clog2(CELLS / B_UNITS);
  localparam int DW_A = UNIT_W * A_UNITS;
  localparam int DW_B = UNIT_W * B_UNITS;

  logic [UNIT_W-1:0] mem [CELLS];

  // ****************************************
  // Effective mode
  // ****************************************
  erb_mode_e mode;
  logic clr_in;
  logic flow;

  always_comb begin
    mode = i_mode;
    if (SIZE == ERB_SMALL && i_mode == ERB_TRUE_DP) begin
      mode = ERB_SIMPLE_DP;
    end
    if (SIZE != ERB_MEDIUM && i_mode == ERB_TWO_SINGLE) begin
      mode = ERB_SINGLE;
    end
  end

  assign clr_in = i_clr && (SIZE != ERB_LARGE);
  assign flow = i_flow && (mode == ERB_SIMPLE_DP) && (SIZE != ERB_LARGE);

  // ****************************************
  // Input registers
  // ****************************************
  logic [AW_A-1:0] a_addr;
  logic [DW_A-1:0] a_wdata;
  logic a_wren;
  logic a_rden;
  logic [AW_B-1:0] b_addr;
  logic [DW_B-1:0] b_wdata;
  logic b_wren;
  logic b_rden;
  logic [AW_B-1:0] b_addr_n;
  logic b_rden_n;

  always_ff @(posedge i_clk) begin
    if (i_rst || clr_in) begin
      a_addr <= '0;
      a_wdata <= '0;
      a_wren <= 1'b0;
      a_rden <= 1'b0;
      b_addr <= '0;
      b_wdata <= '0;
      b_wren <= 1'b0;
      b_rden <= 1'b0;
    end else begin
      a_addr <= i_a_addr;
      a_wdata <= i_a_wdata;
      a_wren <= i_a_wren;
      a_rden <= i_a_rden;
      b_addr <= i_b_addr;
      b_wdata <= i_b_wdata;
      b_wren <= i_b_wren;
      b_rden <= i_b_rden;
    end
  end

  always_ff @(negedge i_clk) begin
    if (i_rst || clr_in) begin
      b_addr_n <= '0;
      b_rden_n <= 1'b0;
    end else begin
      b_addr_n <= i_b_addr;
      b_rden_n <= i_b_rden;
    end
  end

  // ****************************************
  // Port roles and cell positions
  // ****************************************
  logic single;
  logic a_we;
  logic a_re;
  logic b_we;
  logic b_re;
  int a_base;
  int b_base;

  assign single = (mode == ERB_SINGLE) || (mode == ERB_TWO_SINGLE);

  // write wins over read on a port, except port B in simple dual-port, which ignores its write and reads
  always_comb begin
    a_we = a_wren;
    a_re = a_rden && !a_wren && (mode != ERB_SIMPLE_DP);
    b_we = b_wren && (mode == ERB_TRUE_DP || mode == ERB_TWO_SINGLE);
    b_re = b_rden && !b_wren && (mode != ERB_SINGLE);
    if (mode == ERB_SIMPLE_DP) begin
      b_re = flow ? b_rden_n : b_rden;
    end
  end

  // each memory in its own half
  always_comb begin
    a_base = int'(a_addr) * A_UNITS;
    b_base = int'(flow ? b_addr_n : b_addr) * B_UNITS;
    if (mode == ERB_TWO_SINGLE) begin
      a_base = a_base % HALF;
      b_base = HALF + (b_base % HALF);
    end
  end

  // ****************************************
  // Array write and read
  // ****************************************
  // self-timed write on clock
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < A_UNITS; i++) begin
      if (a_we && a_base + i < CELLS) begin
        mem[a_base+i] <= a_wdata[i*UNIT_W +: UNIT_W];
      end
    end
    for (int i = 0; i < B_UNITS; i++) begin
      if (b_we && b_base + i < CELLS) begin
        mem[b_base+i] <= b_wdata[i*UNIT_W +: UNIT_W];
      end
    end
  end

  logic [DW_A-1:0] a_rd;
  logic [DW_B-1:0] b_rd;
  logic collide;

  always_comb begin
    a_rd = '0;
    b_rd = '0;
    for (int i = 0; i < A_UNITS; i++) begin
      if (a_base + i < CELLS) begin
        a_rd[i*UNIT_W +: UNIT_W] = mem[a_base+i];
      end
    end
    for (int i = 0; i < B_UNITS; i++) begin
      if (b_base + i < CELLS) begin
        b_rd[i*UNIT_W +: UNIT_W] = mem[b_base+i];
      end
    end
  end

  assign collide = (mode == ERB_SIMPLE_DP) && a_we && b_re &&
    (a_base < b_base + B_UNITS) && (b_base < a_base + A_UNITS);

  // ****************************************
  // Output stages
  // ****************************************
  logic a_load;
  logic b_load;
  logic [DW_A-1:0] a_data;
  logic [DW_B-1:0] b_data;

  // written data shown in single-port use
  always_comb begin
    a_load = a_re || (a_we && single);
    a_data = a_re ? a_rd : a_wdata;
    b_load = b_re || (b_we && mode == ERB_TWO_SINGLE);
    b_data = b_re ? b_rd : b_wdata;
    if (b_re && collide && !i_old_data) begin
      b_data = {DW_B{ERB_UNDEF_BIT}};
    end
  end

  erb_out_stage #(.W(DW_A)) u_out_a (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clr(i_clr),
    .i_use_reg(i_out_reg_a),
    .i_load(a_load),
    .i_data(a_data),
    .o_q(o_a_q)
  );

  erb_out_stage #(.W(DW_B)) u_out_b (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clr(i_clr),
    .i_use_reg(i_out_reg_b),
    .i_load(b_load),
    .i_data(b_data),
    .o_q(o_b_q)
  );

endmodule

//--- erb_ram_properties.sv
/*
  Port timing checker of the RAM block.
  Bound to erb_ram; one clock, synchronous reset.
*/
module erb_ram_chk
  import erb_pkg::*;
#(
  parameter erb_size_e SIZE = ERB_MEDIUM,
  parameter int UNIT_W = 1,
  parameter int A_UNITS = 1,
  parameter int B_UNITS = 16,
  localparam int C = erb_bits(SIZE) / UNIT_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire erb_mode_e i_mode,
  input wire logic i_clr,
  input wire logic i_out_reg_a,
  input wire logic i_out_reg_b,
  input wire logic i_old_data,
  input wire logic i_flow,
  input wire logic [$clog2(C/A_UNITS)-1:0] i_a_addr,
  input wire logic [UNIT_W*A_UNITS-1:0] i_a_wdata,
  input wire logic i_a_wren,
  input wire logic i_a_rden,
  input wire logic [$clog2(C/B_UNITS)-1:0] i_b_addr,
  input wire logic i_b_wren,
  input wire logic i_b_rden,
  input wire logic [UNIT_W*A_UNITS-1:0] o_a_q,
  input wire logic [UNIT_W*B_UNITS-1:0] o_b_q
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************
  // Assertions
  // ****************
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  wire logic ra = i_a_wren || i_a_rden;
  wire logic rb = i_b_wren || i_b_rden;
  wire logic sa = i_mode == ERB_SINGLE && i_a_wren && !i_clr;

  rst_out_zero_a: assert property (
    $fell(i_rst) |-> o_a_q == '0 && o_b_q == '0)
    else $error("output not zero after reset");
  clr_a_zero_a: assert property (
    i_clr |=> o_a_q == '0) else $error("port a not cleared");
  clr_b_zero_a: assert property (
    i_clr |=> o_b_q == '0) else $error("port b not cleared");
  a_change_cause_a: assert property (
    $changed(o_a_q) && !$past(i_clr) && !$past(i_rst)
    |-> $past(ra, 2) || $past(ra, 3)) else $error("port a moved alone");
  b_change_cause_a: assert property (
    $changed(o_b_q) && !$past(i_clr) && !$past(i_rst)
    |-> $past(rb) || $past(rb, 2) || $past(rb, 3))
    else $error("port b moved alone");
  write_thru_a: assert property (
    (sa && !i_out_reg_a) ##1 !i_clr |=> o_a_q == $past(i_a_wdata, 2))
    else $error("bypass write not shown");
  reg_delay_a: assert property (
    (sa && i_out_reg_a) ##1 !i_clr [*2] |=> o_a_q == $past(i_a_wdata, 3))
    else $error("registered write not shown");
  collide_ones_a: assert property (
    (i_mode == ERB_SIMPLE_DP && i_a_wren && i_b_rden && !i_old_data
     && !i_flow && !i_out_reg_b && !i_clr
     && (i_a_addr * A_UNITS) / B_UNITS == i_b_addr) ##1 !i_clr
    |=> &o_b_q) else $error("collision not all ones");
endmodule

bind erb_ram erb_ram_chk #(.SIZE(SIZE), .UNIT_W(UNIT_W),
  .A_UNITS(A_UNITS), .B_UNITS(B_UNITS)) erb_ram_chk_inst (.*);

//--- erb_user_model.sv
/*
  Fabric user logic that issues requests to the RAM block.
  Assumes the bench calls its tasks; drives just after rising edges.
*/
module erb_user (
  input wire logic i_clk,
  output logic [12:0] o_a_addr,
  output logic o_a_wdata,
  output logic o_a_wren,
  output logic o_a_rden,
  output logic [8:0] o_b_addr,
  output logic [15:0] o_b_wdata,
  output logic o_b_wren,
  output logic o_b_rden
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {o_a_addr, o_a_wdata, o_a_wren, o_a_rden} = '0;
    {o_b_addr, o_b_wdata, o_b_wren, o_b_rden} = '0;
  end

  task automatic req(input logic aw, ar, input logic [12:0] aa,
                     input logic ad, bw, br, input logic [8:0] ba,
                     input logic [15:0] bd);
    @(posedge i_clk) #1;
    {o_a_wren, o_a_rden, o_a_addr, o_a_wdata} = {aw, ar && !aw, aa, ad};
    {o_b_wren, o_b_rden, o_b_addr, o_b_wdata} = {bw, br && !bw, ba, bd};
  endtask

  // Released lines show no stale data
  task automatic idle();
    @(posedge i_clk) #1;
    {o_a_wren, o_a_rden, o_b_wren, o_b_rden} = '0;
    {o_a_addr, o_a_wdata, o_b_addr, o_b_wdata} =
      ~{o_a_addr, o_a_wdata, o_b_addr, o_b_wdata};
  endtask
endmodule

//--- tb_erb_ram.sv
/*
  Self-checking bench of the medium RAM block, 1-bit A, 16-bit B.
  Assumes erb_pkg, erb_ram and erb_user are compiled before it.
*/
module tb_erb_ram
  import erb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] D = 16'hA5C3;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  erb_mode_e i_mode = ERB_SINGLE;
  logic i_clr = 1'h0, ora = 1'h0, old = 1'h1, flow = 1'h0, orb = 1'h0;
  logic [12:0] a_addr;
  logic [8:0] b_addr;
  logic [15:0] b_d, o_b_q;
  logic a_d, a_we, a_re, b_we, b_re, o_a_q;
  int num_errors = 0, num_checks = 0;

  always #25 i_clk = ~i_clk;

  erb_user erb_user_inst (.i_clk(i_clk), .o_a_addr(a_addr),
    .o_a_wdata(a_d), .o_a_wren(a_we), .o_a_rden(a_re),
    .o_b_addr(b_addr), .o_b_wdata(b_d), .o_b_wren(b_we),
    .o_b_rden(b_re));
  erb_ram #(.SIZE(ERB_MEDIUM), .UNIT_W(1), .A_UNITS(1), .B_UNITS(16))
  erb_ram_inst (.i_clk(i_clk), .i_rst(i_rst), .i_mode(i_mode),
    .i_clr(i_clr), .i_out_reg_a(ora), .i_out_reg_b(orb),
    .i_old_data(old), .i_flow(flow), .i_a_addr(a_addr),
    .i_a_wdata(a_d), .i_a_wren(a_we), .i_a_rden(a_re),
    .i_b_addr(b_addr), .i_b_wdata(b_d), .i_b_wren(b_we),
    .i_b_rden(b_re), .o_a_q(o_a_q), .o_b_q(o_b_q));

  // ****************
  // Helpers
  // ****************
  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step();
    erb_user_inst.idle();
    @(posedge i_clk) #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_single();
    erb_user_inst.req(1, 0, 13'h7, 1, 0, 0, 0, 0);
    step();
    check("single bypass", o_a_q, 1);
    ora = 1'h1;
    erb_user_inst.req(1, 0, 13'h7, 0, 0, 0, 0, 0);
    step();
    check("reg early", o_a_q, 1);
    @(posedge i_clk) #1;
    check("reg late", o_a_q, 0);
    ora = 1'h0;
    $display("single port done");
  endtask

  task automatic t_mixed();
    i_mode = ERB_SIMPLE_DP;
    for (int i = 0; i < 16; i++)
      erb_user_inst.req(1, 0, 13'(32 + i), D[i], 0, 0, 0, 0);
    erb_user_inst.idle();
    erb_user_inst.req(0, 0, 0, 0, 0, 1, 9'h2, 0);
    step();
    check("mixed width", o_b_q, D);
    for (int k = 0; k < 2; k++) begin
      erb_user_inst.req(1, 0, 13'h20, 0, 0, 1, 9'h2, 0);
      step();
      check("collision", o_b_q, k ? 16'hFFFF : D);
      old = 1'h0;
    end
    $display("mixed width done");
  endtask

  task automatic t_clear_flow();
    erb_user_inst.req(0, 0, 0, 0, 0, 1, 9'h2, 0);
    i_clr = 1'h1;
    erb_user_inst.idle();
    i_clr = 1'h0;
    check("clear out", o_b_q, 0);
    @(posedge i_clk) #1;
    check("clear input", o_b_q, 0);
    flow = 1'h1;
    erb_user_inst.req(0, 0, 0, 0, 0, 1, 9'h2, 0);
    erb_user_inst.idle();
    check("flow through", o_b_q, 16'hA5C2);
    flow = 1'h0;
    $display("clear and flow done");
  endtask

  task automatic t_dual();
    i_mode = ERB_TRUE_DP;
    erb_user_inst.req(0, 1, 13'h28, 0, 1, 0, 9'h3, 16'h1234);
    step();
    check("dual a read", o_a_q, 1);
    erb_user_inst.req(0, 1, 13'h30, 0, 0, 1, 9'h3, 0);
    step();
    check("dual a second", o_a_q, 0);
    check("dual b read", o_b_q, 16'h1234);
    orb = 1'h1;
    erb_user_inst.req(0, 0, 0, 0, 0, 1, 9'h2, 0);
    step();
    check("b reg early", o_b_q, 16'h1234);
    @(posedge i_clk) #1;
    check("b reg late", o_b_q, 16'hA5C2);
    orb = 1'h0;
    i_mode = ERB_TWO_SINGLE;
    erb_user_inst.req(1, 0, 0, 0, 1, 0, 0, 16'hFFFF);
    erb_user_inst.req(0, 1, 0, 0, 0, 1, 0, 0);
    step();
    check("half a", o_a_q, 0);
    check("half b", o_b_q, 16'hFFFF);
    $display("dual port done");
  endtask

  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    i_rst = 1'h0;
    t_single();
    t_mixed();
    t_clear_flow();
    t_dual();
    give_verdict();
  end
endmodule
